// ==== rtl/dep_pkg.sv ====
// Constants and types for the discrete event packet builder
package dep_pkg;
   // APB register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_INTV = 8'h04;
   localparam logic [7:0] OFF_NEVT = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] OFF_LAST = 8'h10;
   // Control register fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_LEN_LSB = 4;
   localparam int CTRL_ABS = 9;
   localparam int CTRL_TFMT_LSB = 10;
   // Status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_PEND = 1;
   localparam int STAT_OVF = 2;
   localparam int STAT_LVL_LSB = 8;
   // Channel word fields
   localparam int CW_MODE_LSB = 0;
   localparam int CW_LEN_LSB = 3;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] INTV_RST = 32'h0000_03E8;
   localparam logic [7:0] NEVT_RST = 8'h01;
   localparam logic [31:0] TICK_RST = 32'h0000_0000;
   // Packet emitter states
   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_CHLO = 4'b0001,
      S_CHHI = 4'b0010,
      S_TS0 = 4'b0011,
      S_TS1 = 4'b0100,
      S_TS2 = 4'b0101,
      S_TS3 = 4'b0110,
      S_ST0 = 4'b0111,
      S_ST1 = 4'b1000,
      S_WAIT = 4'b1001
   } dep_state_e;
endpackage

// ==== rtl/dep_builder.sv ====
// Discrete event packet builder: APB control, event capture, packet framing and output FIFO
`timescale 1ns/1ns
`default_nettype none

// Output FIFO with a registered output stage
module dep_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic ov_q, ov_d, push, pop;
   logic [WIDTH-1:0] od_q, od_d;

   // Pop into the output stage whenever it is empty or being drained
   always_comb begin
      push = in_valid && in_ready;
      pop = (cnt_q != '0) && (!ov_q || out_ready);
      wr_d = push ? wr_q + AW'(1) : wr_q;
      rd_d = pop ? rd_q + AW'(1) : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
      od_d = pop ? mem[rd_q] : od_q;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         ov_q <= 1'b0;
         od_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         ov_q <= ov_d;
         od_q <= od_d;
      end
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = ov_q;
   assign out_data = od_q;
   assign level = cnt_q;
endmodule // dep_fifo

// Contract
// - Each event records one to 32 inputs
// - Channel word first, low half first
// - Channel word bits 31-8 reserved
// - Event bit count at bits 7-3
// - Bit count zero means 32 bits
// - Mode in bits 2-0, bit 2 reserved
// - Mode bit 0: change or interval trigger
// - Mode bit 1: LSB or MSB alignment
// - Event holds state word and time stamp
// - State bit n is input n level
// - Time stamp header precedes state word
// - Header is eight bytes, low long first
// - Time stamp as four words, LS first
// - State word two halves after time stamp
// - Relative time: 48 bits, top zero
// - Flag selects absolute time stamp instead
// - Events in order, trailer after last; no trailer word is built, out_last marks the final state word
module dep_builder #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] discrete_in,
   input wire logic [47:0] rel_time,
   input wire logic [63:0] abs_time,
   output logic abs_time_en,
   output logic [1:0] time_fmt,
   output logic [15:0] out_data,
   output logic out_last,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   logic [31:0] ctrl_q, ctrl_d, intv_q, intv_d, tick_q, tick_d;
   logic [7:0] nevt_q, nevt_d, evc_q, evc_d;
   logic ovf_q, ovf_d, pend_q, pend_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic [31:0] in_q, last_q, last_d, mask, fmt_state, chan_word;
   logic [63:0] pts_q, pts_d, cts_q, cts_d;
   logic [31:0] pst_q, pst_d, cst_q, cst_d;
   dep_pkg::dep_state_e st_q, st_d;
   logic [4:0] len;
   logic active, tick, changed, trig, take, cap, last_ev, acc, wr_en;
   logic push_valid, push_ready, push_last;
   logic [15:0] push_data;
   logic [LW-1:0] level;
   logic [16:0] fifo_word;

   // Control fields; reserved mode bit 2 is never stored
   assign len = ctrl_q[dep_pkg::CTRL_LEN_LSB +: 5];
   assign chan_word = {24'h00_0000, len, 1'b0, ctrl_q[dep_pkg::CTRL_MODE_LSB +: 2]};

   // Per-bit mask of recorded inputs: bit i used when i < length or length is zero
   for (genvar gi = 0; gi < 32; gi++) begin : g_mask
      assign mask[gi] = (len == 5'd0) || (5'(gi) < len);
   end

   // Align the recorded inputs; unused positions read zero
   always_comb begin
      fmt_state = in_q & mask;
      if (ctrl_q[dep_pkg::CTRL_MODE_LSB + 1] && len != 5'd0) begin
         fmt_state = fmt_state << (6'd32 - {1'b0, len});
      end
   end

   // Inputs are registered once so the change compare sees a stable word
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         in_q <= 32'h0000_0000;
      end else begin
         in_q <= discrete_in;
      end
   end

   // Trigger selection; capture runs while enabled or a packet is open
   always_comb begin
      active = ctrl_q[dep_pkg::CTRL_EN] || (st_q != dep_pkg::S_IDLE);
      tick = active && (intv_q <= 32'd1 || tick_q >= intv_q - 32'd1);
      tick_d = (!active || tick) ? dep_pkg::TICK_RST : tick_q + 32'd1;
      changed = ((in_q ^ last_q) & mask) != 32'h0000_0000;
      trig = active && (ctrl_q[dep_pkg::CTRL_MODE_LSB] ? tick : changed);
      take = pend_q && ((st_q == dep_pkg::S_IDLE && ctrl_q[dep_pkg::CTRL_EN]) || st_q == dep_pkg::S_WAIT);
      cap = trig && (!pend_q || take);
      pend_d = cap ? 1'b1 : (take ? 1'b0 : pend_q);
      last_d = cap ? in_q : last_q;
      pst_d = cap ? fmt_state : pst_q;
      pts_d = cap ? (ctrl_q[dep_pkg::CTRL_ABS] ? abs_time : {16'h0000, rel_time}) : pts_q;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_q <= dep_pkg::TICK_RST;
         pend_q <= 1'b0;
         last_q <= 32'h0000_0000;
         pst_q <= 32'h0000_0000;
         pts_q <= 64'h0000_0000_0000_0000;
      end else begin
         tick_q <= tick_d;
         pend_q <= pend_d;
         last_q <= last_d;
         pst_q <= pst_d;
         pts_q <= pts_d;
      end
   end

   // Packet framing; each state from S_CHLO to S_ST1 pushes one 16-bit word and waits on FIFO room, S_IDLE and S_WAIT push nothing
   always_comb begin
      st_d = st_q;
      cts_d = take ? pts_q : cts_q;
      cst_d = take ? pst_q : cst_q;
      evc_d = evc_q;
      push_valid = 1'b0;
      push_data = 16'h0000;
      last_ev = ({1'b0, evc_q} + 9'd1) >= {1'b0, nevt_q};
      push_last = 1'b0;
      case (st_q)
         dep_pkg::S_IDLE: begin
            evc_d = 8'h00;
            if (take) begin
               st_d = dep_pkg::S_CHLO;
            end
         end
         dep_pkg::S_WAIT: begin
            if (take) begin
               st_d = dep_pkg::S_TS0;
            end
         end
         dep_pkg::S_CHLO: begin
            push_valid = 1'b1;
            push_data = chan_word[15:0];
            if (push_ready) begin
               st_d = dep_pkg::S_CHHI;
            end
         end
         dep_pkg::S_CHHI: begin
            push_valid = 1'b1;
            push_data = chan_word[31:16];
            if (push_ready) begin
               st_d = dep_pkg::S_TS0;
            end
         end
         dep_pkg::S_TS0, dep_pkg::S_TS1, dep_pkg::S_TS2, dep_pkg::S_TS3: begin
            push_valid = 1'b1;
            push_data = cts_q[16 * (st_q - dep_pkg::S_TS0) +: 16];
            if (push_ready) begin
               st_d = dep_pkg::dep_state_e'(st_q + 4'd1);
            end
         end
         dep_pkg::S_ST0: begin
            push_valid = 1'b1;
            push_data = cst_q[15:0];
            if (push_ready) begin
               st_d = dep_pkg::S_ST1;
            end
         end
         dep_pkg::S_ST1: begin
            push_valid = 1'b1;
            push_data = cst_q[31:16];
            push_last = last_ev;
            if (push_ready) begin
               evc_d = evc_q + 8'd1;
               st_d = last_ev ? dep_pkg::S_IDLE : dep_pkg::S_WAIT;
            end
         end
         default: begin
            st_d = dep_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= dep_pkg::S_IDLE;
         cts_q <= 64'h0000_0000_0000_0000;
         cst_q <= 32'h0000_0000;
         evc_q <= 8'h00;
      end else begin
         st_q <= st_d;
         cts_q <= cts_d;
         cst_q <= cst_d;
         evc_q <= evc_d;
      end
   end

   // Output FIFO; a full FIFO stalls the framer, so triggers while an event is pending and not taken that cycle are lost and set the overflow flag
   dep_fifo #(
      .WIDTH(17),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data({push_last, push_data}),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(fifo_word),
      .level(level)
   );
   assign out_last = fifo_word[16];
   assign out_data = fifo_word[15:0];

   // APB slave: one wait state, so pready is a flop and reads are registered
   always_comb begin
      acc = psel && penable;
      wr_en = acc && pready_q && pwrite;
      pready_d = acc && !pready_q;
      pslverr_d = 1'b0;
      prdata_d = 32'h0000_0000;
      ctrl_d = ctrl_q;
      intv_d = intv_q;
      nevt_d = nevt_q;
      ovf_d = ovf_q || (trig && pend_q && !take);
      if (pready_d) begin
         if (paddr == dep_pkg::OFF_CTRL) begin
            prdata_d = ctrl_q;
         end else if (paddr == dep_pkg::OFF_INTV) begin
            prdata_d = intv_q;
         end else if (paddr == dep_pkg::OFF_NEVT) begin
            prdata_d = {24'h00_0000, nevt_q};
         end else if (paddr == dep_pkg::OFF_STAT) begin
            prdata_d[dep_pkg::STAT_BUSY] = st_q != dep_pkg::S_IDLE;
            prdata_d[dep_pkg::STAT_PEND] = pend_q;
            prdata_d[dep_pkg::STAT_OVF] = ovf_q;
            prdata_d[dep_pkg::STAT_LVL_LSB +: LW] = level;
         end else if (paddr == dep_pkg::OFF_LAST) begin
            prdata_d = last_q;
         end else begin
            pslverr_d = 1'b1;
         end
      end
      if (wr_en) begin
         if (paddr == dep_pkg::OFF_CTRL) begin
            ctrl_d = {20'h0_0000, pwdata[11:4], 1'b0, pwdata[2:0]};
         end else if (paddr == dep_pkg::OFF_INTV) begin
            intv_d = pwdata;
         end else if (paddr == dep_pkg::OFF_NEVT) begin
            nevt_d = pwdata[7:0];
         end else if (paddr == dep_pkg::OFF_STAT && pwdata[dep_pkg::STAT_OVF]) begin
            // A lost event in the clearing cycle keeps the flag set
            ovf_d = trig && pend_q && !take;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= dep_pkg::CTRL_RST;
         intv_q <= dep_pkg::INTV_RST;
         nevt_q <= dep_pkg::NEVT_RST;
         ovf_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         intv_q <= intv_d;
         nevt_q <= nevt_d;
         ovf_q <= ovf_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign abs_time_en = ctrl_q[dep_pkg::CTRL_ABS];
   assign time_fmt = ctrl_q[dep_pkg::CTRL_TFMT_LSB +: 2];

   // Checks on framing and capture; a full FIFO may hold any state, so no step assumes room
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_chan_words;
      (st_q == dep_pkg::S_CHLO && push_ready) ##1 (st_q == dep_pkg::S_CHHI);
   endsequence
   sequence s_ts_start;
      (st_q == dep_pkg::S_CHHI && push_ready) ##1 (st_q == dep_pkg::S_TS0);
   endsequence
   property p_chan_first;
      (st_q == dep_pkg::S_IDLE && take) |=> st_q == dep_pkg::S_CHLO;
   endproperty
   a_chan_first: assert property (p_chan_first) else $error("channel word not first");
   property p_chan_fields;
      s_chan_words |-> push_valid && push_data == 16'h0000;
   endproperty
   a_chan_fields: assert property (p_chan_fields) else $error("reserved channel bits set");
   property p_chan_low;
      push_valid && st_q == dep_pkg::S_CHLO |-> push_data[7:3] == len && push_data[2] == 1'b0;
   endproperty
   a_chan_low: assert property (p_chan_low) else $error("length or mode field wrong");
   property p_full_len;
      len == 5'd0 |-> mask == 32'hFFFF_FFFF;
   endproperty
   a_full_len: assert property (p_full_len) else $error("zero length not 32 bits");
   property p_change_cap;
      (active && !ctrl_q[dep_pkg::CTRL_MODE_LSB] && changed && !pend_q) |=> pend_q && pst_q == $past(fmt_state);
   endproperty
   a_change_cap: assert property (p_change_cap) else $error("change not captured");
   property p_unused_zero;
      cap |=> (pst_q & ~(ctrl_q[dep_pkg::CTRL_MODE_LSB + 1] ? mask << (6'd32 - {1'b0, len}) : mask)) == 32'h0 || len == 5'd0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused state bits not zero");
   property p_rel_top;
      (cap && !ctrl_q[dep_pkg::CTRL_ABS]) |=> pts_q[63:48] == 16'h0000 && pts_q[47:0] == $past(rel_time);
   endproperty
   a_rel_top: assert property (p_rel_top) else $error("relative stamp wrong");
   property p_ts_then_state;
      (st_q == dep_pkg::S_TS3 && push_ready) |=> st_q == dep_pkg::S_ST0 && push_data == cst_q[15:0];
   endproperty
   a_ts_then_state: assert property (p_ts_then_state) else $error("state not after stamp");
   property p_ts_order;
      s_ts_start |-> push_data == cts_q[15:0];
   endproperty
   a_ts_order: assert property (p_ts_order) else $error("stamp not low word first");
endmodule // dep_builder

`default_nettype wire

// ==== sim/dep_sink.sv ====
// Recording stream sink model that stores every packet word it accepts
`timescale 1ns/1ns
`default_nettype none

module dep_sink (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] out_data,
   input wire logic out_last,
   input wire logic out_valid,
   output logic out_ready,
   input wire logic hold,
   input wire logic slow
);
   logic [15:0] words[$];
   logic lasts[$];
   logic phase_q;

   // Ready follows the stall controls; slow mode accepts every other cycle
   assign out_ready = !hold && (!slow || phase_q);

   // Store a word only at an edge where both sides agree
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= !phase_q;
         if (out_valid && out_ready) begin
            words.push_back(out_data);
            lasts.push_back(out_last);
         end
      end
   end
endmodule // dep_sink

`default_nettype wire

// ==== sim/discrete_event_packet_builder_tb.sv ====
// Testbench for the discrete event packet builder
`timescale 1ns/1ns
`default_nettype none

module discrete_event_packet_builder_tb;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, abs_time_en, out_last, out_valid, out_ready;
   logic hold, slow, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, discrete_in, rd;
   logic [47:0] rel_time;
   logic [63:0] abs_time;
   logic [1:0] time_fmt;
   logic [15:0] out_data;
   logic [15:0] exp_q[$];
   int mismatches, samples_checked;

   dep_builder dep_builder_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .discrete_in(discrete_in), .rel_time(rel_time), .abs_time(abs_time), .abs_time_en(abs_time_en),
      .time_fmt(time_fmt), .out_data(out_data), .out_last(out_last), .out_valid(out_valid),
      .out_ready(out_ready));
   dep_sink dep_sink_i (.clk(clk), .resetn(resetn), .out_data(out_data), .out_last(out_last),
      .out_valid(out_valid), .out_ready(out_ready), .hold(hold), .slow(slow));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("TB: checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; request held until pready is seen high at a rising edge, data taken there
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         mismatches++;
         report_and_stop();
      end
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask

   // Waits for a whole packet, then compares words and the end marker
   task automatic pkt(input string nm);
      int n;
      n = 0;
      while (dep_sink_i.words.size() < exp_q.size() && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) begin
         mismatches++;
         report_and_stop();
      end
      foreach (exp_q[i]) begin
         chk(nm, {16'h0000, exp_q[i]}, {16'h0000, dep_sink_i.words[i]});
         chk("last", {31'h0000_0000, i == exp_q.size() - 1}, {31'h0000_0000, dep_sink_i.lasts[i]});
      end
      $display("TB: test %s done", nm);
   endtask

   initial begin
      {psel, penable, pwrite, hold, slow} = 5'b0_0000;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      discrete_in = 32'h0000_0000;
      rel_time = 48'h0ABC_DEF0_1234;
      abs_time = 64'h1122_3344_5566_7788;
      resetn = 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      // Register reset values, reserved control bit, unmapped address
      rdchk("ctrl", dep_pkg::OFF_CTRL, dep_pkg::CTRL_RST);
      rdchk("intv", dep_pkg::OFF_INTV, dep_pkg::INTV_RST);
      rdchk("nevt", dep_pkg::OFF_NEVT, {24'h00_0000, dep_pkg::NEVT_RST});
      chk("slverr_ok", 32'h0000_0000, {31'h0000_0000, er});
      apb(1'b1, dep_pkg::OFF_CTRL, 32'h0000_0FFE);
      rdchk("ctrl_rsv", dep_pkg::OFF_CTRL, 32'h0000_0FF6);
      rdchk("unmapped", 8'h14, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0000_0000, er});
      $display("TB: test regs done");
      // Change trigger, MSB alignment, 4 bits, absolute time, slow sink
      apb(1'b1, dep_pkg::OFF_NEVT, 32'h0000_0001);
      slow <= 1'b1;
      apb(1'b1, dep_pkg::OFF_CTRL, 32'h0000_0A45);
      @(posedge clk);
      discrete_in <= 32'hFFFF_FFF5;
      exp_q = '{16'h0022, 16'h0000, 16'h7788, 16'h5566, 16'h3344, 16'h1122, 16'h0000, 16'h5000};
      pkt("change");
      chk("abs_en", 32'h0000_0001, {31'h0000_0000, abs_time_en});
      chk("tfmt", 32'h0000_0002, {30'h0000_0000, time_fmt});
      repeat (50) @(posedge clk);
      chk("no_retrigger", 32'h0000_0008, dep_sink_i.words.size());
      rdchk("last_in", dep_pkg::OFF_LAST, 32'hFFFF_FFF5);
      // Interval trigger, 32 bits, relative time, stalled sink fills the buffer
      apb(1'b1, dep_pkg::OFF_CTRL, 32'h0000_0000);
      hold <= 1'b1;
      slow <= 1'b0;
      dep_sink_i.words.delete();
      dep_sink_i.lasts.delete();
      apb(1'b1, dep_pkg::OFF_NEVT, 32'h0000_0003);
      apb(1'b1, dep_pkg::OFF_INTV, 32'h0000_0003);
      discrete_in <= 32'hA5C3_0F96;
      apb(1'b1, dep_pkg::OFF_CTRL, 32'h0000_0003);
      repeat (100) @(posedge clk);
      apb(1'b0, dep_pkg::OFF_STAT, 32'h0000_0000);
      chk("fifo_level", 32'h0000_0010, {27'h000_0000, rd[12:8]});
      chk("overflow", 32'h0000_0001, {31'h0000_0000, rd[2]});
      hold <= 1'b0;
      exp_q = '{16'h0001, 16'h0000};
      repeat (3) exp_q = {exp_q, 16'h1234, 16'hDEF0, 16'h0ABC, 16'h0000, 16'h0F96, 16'hA5C3};
      pkt("interval");
      // Disable, let the open packet finish, then clear the lost-event flag
      apb(1'b1, dep_pkg::OFF_CTRL, 32'h0000_0000);
      repeat (50) @(posedge clk);
      apb(1'b1, dep_pkg::OFF_STAT, 32'h0000_0004);
      apb(1'b0, dep_pkg::OFF_STAT, 32'h0000_0000);
      chk("ovf_clear", 32'h0000_0000, {31'h0000_0000, rd[2]});
      chk("idle", 32'h0000_0000, {31'h0000_0000, rd[0]});
      $display("TB: test ovf_clear done");
      report_and_stop();
   end
endmodule // discrete_event_packet_builder_tb

`default_nettype wire
